//--- ivp_pkg.sv
/*
 * Shared constants for the interrupt vector placement block: the control
 * register layout, the Avalon-MM register map, vector numbers and the
 * unlock window length.
 * Assumes a single core clock domain and word-addressed program memory.
 */
package ivp_pkg;

    // ==========================================================
    // Register map (byte addresses, one aligned word each)
    // ==========================================================
    localparam logic [3:0] ADDR_MCU_CONTROL    = 4'h0;
    localparam logic [3:0] ADDR_PLACEMENT      = 4'h4;
    localparam logic [3:0] ADDR_VECTOR_QUERY   = 4'h8;
    localparam logic [3:0] ADDR_VECTOR_ADDRESS = 4'hC;
    localparam int         ADDR_W              = 4;

    // ==========================================================
    // Control register fields
    // ==========================================================
    localparam int         BIT_CHANGE_UNLOCK   = 0;
    localparam int         BIT_BASE_SELECT     = 1;
    localparam int         BIT_PULLUP_DISABLE  = 4;
    localparam int         BIT_DEBUG_DISABLE   = 7;
    localparam logic [7:0] MCU_CONTROL_RESET   = 8'h00;
    localparam logic [7:0] MCU_CONTROL_WMASK   = 8'h93;

    // ==========================================================
    // Placement status register fields
    // ==========================================================
    localparam int BIT_ST_BLOCK   = 0;
    localparam int BIT_ST_LOCKOUT = 1;
    localparam int BIT_ST_IN_BOOT = 2;

    // ==========================================================
    // Vector table
    // ==========================================================
    localparam int          PC_W               = 16;
    localparam int          VEC_NUM_W          = 6;
    localparam logic [5:0]  VEC_FIRST          = 6'h01;
    localparam logic [5:0]  VEC_LAST           = 6'h26;
    localparam logic [5:0]  VEC_T3_CAPTURE     = 6'h20;
    localparam logic [5:0]  VEC_T3_COMPARE_A   = 6'h21;
    localparam logic [5:0]  VEC_T3_COMPARE_B   = 6'h22;
    localparam logic [5:0]  VEC_T3_COMPARE_C   = 6'h23;
    localparam logic [5:0]  VEC_T3_OVERFLOW    = 6'h24;
    localparam logic [5:0]  VEC_TWO_WIRE       = 6'h25;
    localparam logic [5:0]  VEC_PROG_STORE_RDY = 6'h26;
    localparam logic [15:0] RESET_ADDR_APP     = 16'h0000;
    localparam logic [15:0] FIRST_IRQ_OFFSET   = 16'h0002;

    // ==========================================================
    // Boot section start, word address per boot size fuse code
    // ==========================================================
    localparam logic [15:0] BOOT_START_SZ0 = 16'hF000;
    localparam logic [15:0] BOOT_START_SZ1 = 16'hF800;
    localparam logic [15:0] BOOT_START_SZ2 = 16'hFC00;
    localparam logic [15:0] BOOT_START_SZ3 = 16'hFE00;

    // ==========================================================
    // Unlock window
    // ==========================================================
    localparam int         UNLOCK_CYCLES = 4;
    localparam logic [2:0] UNLOCK_LOAD   = 3'h4;
    localparam logic [2:0] GUARD_EXTRA   = 3'h1;
    localparam logic [1:0] FUSE_PROG     = 2'h0;

endpackage

//--- ivp_vector_map.sv
/*
 * Vector address calculator: maps a vector number to its program address,
 * relocated to the boot section when requested.
 * Assumes inputs are stable within the cycle; purely combinational.
 */
module ivp_vector_map
    import ivp_pkg::*;
(
    // Query
    input  wire logic [VEC_NUM_W-1:0] vector_num,
    input  wire logic                 relocate,
    input  wire logic [PC_W-1:0]      boot_start,
    // Result
    output logic      [PC_W-1:0]      vector_addr,
    output logic                      vector_valid
);

    // ==========================================================
    // Table address is two words per vector, reset at vector 1
    // ==========================================================
    wire logic [PC_W-1:0] table_addr;
    wire logic [PC_W-1:0] vec_ext;

    assign vec_ext      = PC_W'(vector_num);
    assign table_addr   = PC_W'((vec_ext - 16'h0001) << 1);
    assign vector_addr  = relocate ? PC_W'(table_addr + boot_start)
                                   : table_addr;
    assign vector_valid = (vector_num >= VEC_FIRST) && (vector_num <= VEC_LAST);

endmodule

//--- ivp_top.sv
/*
 * Interrupt vector placement: control register with timed unlock for the
 * vector base select, reset target and vector base outputs, boot-lock
 * interrupt masking and the global pull-up disable.
 * Assumes fuses and lock bits are static straps from the core's domain,
 * the core reports the current fetch address and a retire pulse, and the
 * register bus is Avalon-MM with waitrequest on core_clk.
 */
// The register addresses and the Avalon-MM slave port were left to the implementer.
// Functional notes
// - Timer three vectors sit at 32 to 36.
// - Two-wire at 37, store-ready at 38.
// - Programmed boot fuse starts at boot address.
// - Select clear puts first vector at 0x0002.
// - Select set adds boot start to vectors.
// - Boot start comes from boot size fuses.
// - Unlock clears after four cycles or select write.
// - Interrupts blocked during unlock and after select.
// - Blocking never touches global interrupt flag.
// - Boot vectors plus app lock mask app code.
// - App vectors plus boot lock mask boot code.
// - Pull-up disable bit 4 kills all pull-ups.

module ivp_top
    import ivp_pkg::*;
(
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]    avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    // Fuses and lock bits, zero means programmed
    input  wire logic                 boot_reset_fuse,
    input  wire logic [1:0]           boot_size_fuses,
    input  wire logic                 app_side_boot_lock,
    input  wire logic                 boot_side_boot_lock,
    // Core status
    input  wire logic [PC_W-1:0]      fetch_addr,
    input  wire logic                 instr_retire,
    input  wire logic                 irq_request,
    // Placement outputs
    output logic      [PC_W-1:0]      reset_target,
    output logic      [PC_W-1:0]      vector_base,
    output logic                      irq_gated,
    output logic                      irq_block,
    output logic                      global_pullup_disable,
    output logic                      debug_port_disable
);

    // ==========================================================
    // Bus decode
    // ==========================================================
    typedef enum logic [1:0]
    {
        IVP_IDLE = 2'b00,
        IVP_ACK  = 2'b01
    } ivp_bus_t;

    ivp_bus_t          bus_state;
    ivp_bus_t          next_bus_state;
    wire logic         req;
    wire logic         sel_ctrl;
    wire logic         sel_query;
    wire logic         sel_place;
    wire logic         sel_vaddr;
    wire logic         wr_ctrl;
    wire logic         wr_query;
    wire logic         lane0;

    assign req       = avs_read | avs_write;
    assign sel_ctrl  = avs_address == ADDR_MCU_CONTROL;
    assign sel_query = avs_address == ADDR_VECTOR_QUERY;
    assign sel_place = avs_address == ADDR_PLACEMENT;
    assign sel_vaddr = avs_address == ADDR_VECTOR_ADDRESS;
    assign lane0     = avs_byteenable[0];
    // Write takes effect on the cycle waitrequest is low
    assign wr_ctrl   = avs_write && sel_ctrl && lane0 && (bus_state == IVP_ACK);
    assign wr_query  = avs_write && sel_query && lane0 && (bus_state == IVP_ACK);

    always_comb
    begin
        case (bus_state)
            IVP_IDLE: next_bus_state = req ? IVP_ACK : IVP_IDLE;
            IVP_ACK:  next_bus_state = IVP_IDLE;
            default:  next_bus_state = IVP_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            bus_state <= IVP_IDLE;
        else
            bus_state <= next_bus_state;
    end

    // ==========================================================
    // Fuse straps captured after reset release
    // ==========================================================
    logic              straps_taken;
    logic              boot_reset_prog;
    logic [1:0]        size_code;
    logic              app_lock_prog;
    logic              boot_lock_prog;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            straps_taken    <= 1'b0;
            boot_reset_prog <= 1'b0;
            size_code       <= FUSE_PROG;
            app_lock_prog   <= 1'b0;
            boot_lock_prog  <= 1'b0;
        end
        else if (!straps_taken)
        begin
            straps_taken    <= 1'b1;
            boot_reset_prog <= !boot_reset_fuse;
            size_code       <= boot_size_fuses;
            app_lock_prog   <= !app_side_boot_lock;
            boot_lock_prog  <= !boot_side_boot_lock;
        end
    end

    // ==========================================================
    // Boot section start
    // ==========================================================
    wire logic [PC_W-1:0] boot_start;

    assign boot_start = (size_code == 2'h0) ? BOOT_START_SZ0 :
                        (size_code == 2'h1) ? BOOT_START_SZ1 :
                        (size_code == 2'h2) ? BOOT_START_SZ2 :
                                              BOOT_START_SZ3;

    // ==========================================================
    // Control register and unlock window
    // ==========================================================
    logic              base_select;
    logic              change_unlock;
    logic              pullup_disable;
    logic              debug_disable;
    logic [2:0]        unlock_count;
    logic [2:0]        guard_count;
    wire logic [7:0]   wdata;
    wire logic         wr_unlock_set;
    wire logic         select_write;
    wire logic         unlock_live;
    wire logic         unlock_last;
    wire logic         select_take;

    assign wdata         = avs_writedata[7:0] & MCU_CONTROL_WMASK;
    assign wr_unlock_set = wr_ctrl && wdata[BIT_CHANGE_UNLOCK];
    // Select write is one with unlock written as zero
    assign select_write  = wr_ctrl && !wdata[BIT_CHANGE_UNLOCK];
    assign unlock_live   = change_unlock && (unlock_count != 3'h0);
    // Fourth cycle of the window; unlock drops at its edge
    assign unlock_last   = unlock_count == 3'h1;
    assign select_take   = select_write && unlock_live;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            base_select    <= MCU_CONTROL_RESET[BIT_BASE_SELECT];
            pullup_disable <= MCU_CONTROL_RESET[BIT_PULLUP_DISABLE];
            debug_disable  <= MCU_CONTROL_RESET[BIT_DEBUG_DISABLE];
        end
        else if (wr_ctrl)
        begin
            pullup_disable <= wdata[BIT_PULLUP_DISABLE];
            debug_disable  <= wdata[BIT_DEBUG_DISABLE];
            if (select_take)
                base_select <= wdata[BIT_BASE_SELECT];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            change_unlock <= MCU_CONTROL_RESET[BIT_CHANGE_UNLOCK];
            unlock_count  <= 3'h0;
        end
        else if (wr_unlock_set)
        begin
            change_unlock <= 1'b1;
            unlock_count  <= UNLOCK_LOAD;
        end
        else if (select_write || unlock_last)
        begin
            change_unlock <= 1'b0;
            unlock_count  <= 3'h0;
        end
        else if (unlock_count != 3'h0)
            unlock_count  <= unlock_count - 3'h1;
    end

    // Block runs with unlock, then one more retired instruction after select
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            guard_count <= 3'h0;
        else if (select_take)
            guard_count <= GUARD_EXTRA;
        else if (guard_count != 3'h0 && instr_retire)
            guard_count <= guard_count - 3'h1;
    end

    // ==========================================================
    // Vector placement
    // ==========================================================
    wire logic [PC_W-1:0] base_addr;
    wire logic [PC_W-1:0] next_reset_target;
    wire logic [PC_W-1:0] query_addr;
    wire logic            query_valid;
    logic [VEC_NUM_W-1:0] query_num;

    assign base_addr         = base_select ? PC_W'(boot_start + FIRST_IRQ_OFFSET)
                                           : FIRST_IRQ_OFFSET;
    assign next_reset_target = boot_reset_prog ? boot_start : RESET_ADDR_APP;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            query_num <= VEC_FIRST;
        else if (wr_query)
            query_num <= avs_writedata[VEC_NUM_W-1:0];
    end

    ivp_vector_map u_map
    (
        .vector_num   (query_num),
        .relocate     (base_select),
        .boot_start   (boot_start),
        .vector_addr  (query_addr),
        .vector_valid (query_valid)
    );

    // ==========================================================
    // Interrupt gating
    // ==========================================================
    wire logic in_boot;
    wire logic lockout;
    wire logic next_block;

    assign in_boot    = fetch_addr >= boot_start;
    assign lockout    = (base_select && app_lock_prog && !in_boot)
                      || (!base_select && boot_lock_prog && in_boot);
    // Separate gate; the core's global enable flag is never written
    assign next_block = wr_unlock_set || change_unlock || (guard_count != 3'h0)
                      || select_take;

    // ==========================================================
    // Read data and registered outputs
    // ==========================================================
    wire logic [7:0]  ctrl_rd;
    wire logic [31:0] next_rdata;

    assign ctrl_rd    = {debug_disable, 2'b00, pullup_disable, 2'b00,
                         base_select, change_unlock};
    assign next_rdata = !avs_read ? 32'h0000_0000 :
                        sel_ctrl  ? {24'h00_0000, ctrl_rd} :
                        sel_place ? {29'h0, in_boot, lockout, irq_block} :
                        sel_query ? {26'h0, query_num} :
                        sel_vaddr ? {15'h0, query_valid, query_addr} :
                                    32'h0000_0000;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            avs_readdata          <= 32'h0000_0000;
            avs_waitrequest       <= 1'b1;
            reset_target          <= RESET_ADDR_APP;
            vector_base           <= FIRST_IRQ_OFFSET;
            irq_block             <= 1'b0;
            irq_gated             <= 1'b0;
            global_pullup_disable <= 1'b0;
            debug_port_disable    <= 1'b0;
        end
        else
        begin
            avs_readdata          <= next_rdata;
            avs_waitrequest       <= !(next_bus_state == IVP_ACK);
            reset_target          <= next_reset_target;
            vector_base           <= base_addr;
            irq_block             <= next_block;
            irq_gated             <= irq_request && !next_block && !lockout;
            global_pullup_disable <= pullup_disable;
            debug_port_disable    <= debug_disable;
        end
    end

endmodule

//--- ivp_core_model.sv
/*
 * Behavioural core: follows a fetch address set by the bench and retires
 * one instruction every other cycle.
 * Assumes the bench owns pc_goal and the block samples fetch_addr.
 */
module ivp_core_model
    import ivp_pkg::*;
(
    // Clock and reset
    input  wire logic            core_clk,
    input  wire logic            rst_n,
    // Bench control
    input  wire logic [PC_W-1:0] pc_goal,
    // Core status
    output logic      [PC_W-1:0] fetch_addr,
    output logic                 instr_retire
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========
    // Fetch and retire
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            fetch_addr <= RESET_ADDR_APP;
        else
            fetch_addr <= pc_goal;
    end
    // Steady retires end any select-write block
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            instr_retire <= 1'b0;
        else
            instr_retire <= !instr_retire;
    end
endmodule

//--- ivp_top_properties.sv
/*
 * Port checker for ivp_top.
 * Assumes one core_clk domain; bound to every ivp_top instance.
 */
module ivp_top_properties
    import ivp_pkg::*;
(
    // Clock, reset, bus
    input wire logic              core_clk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_writedata,
    input wire logic [3:0]        avs_byteenable,
    input wire logic [31:0]       avs_readdata,
    input wire logic              avs_waitrequest,
    // Straps and core
    input wire logic              boot_reset_fuse,
    input wire logic [1:0]        boot_size_fuses,
    input wire logic              app_side_boot_lock,
    input wire logic              boot_side_boot_lock,
    input wire logic [PC_W-1:0]   fetch_addr,
    input wire logic              instr_retire,
    input wire logic              irq_request,
    // Outputs
    input wire logic [PC_W-1:0]   reset_target,
    input wire logic [PC_W-1:0]   vector_base,
    input wire logic              irq_gated,
    input wire logic              irq_block,
    input wire logic              global_pullup_disable,
    input wire logic              debug_port_disable
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ==========
    // Helpers
    logic [PC_W-1:0] bs;
    logic            ctl_wr;
    logic            unl_wr;
    logic            lock_c;
    logic [3:0]      since_rst;
    assign bs = boot_size_fuses == 2'h0 ? BOOT_START_SZ0 : boot_size_fuses == 2'h1 ? BOOT_START_SZ1
              : boot_size_fuses == 2'h2 ? BOOT_START_SZ2 : BOOT_START_SZ3;
    assign ctl_wr = avs_write && !avs_waitrequest && avs_address == ADDR_MCU_CONTROL && avs_byteenable[0];
    assign unl_wr = ctl_wr && avs_writedata[BIT_CHANGE_UNLOCK];
    assign lock_c = (vector_base != FIRST_IRQ_OFFSET) ? (!app_side_boot_lock && fetch_addr < bs)
                  : (!boot_side_boot_lock && fetch_addr >= bs);
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            since_rst <= 4'h0;
        else if (since_rst != 4'hF)
            since_rst <= since_rst + 4'h1;
    end
    sequence s_req_rise;
        $rose(avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_unl_quiet;
        unl_wr ##1 (!ctl_wr) [*6];
    endsequence
    // ==========
    // Assertions
    a_wait_answer: assert property (s_req_rise |=> !avs_waitrequest)
        else $error("waitrequest not low one cycle after request");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_unused_zero: assert property (avs_read && !avs_waitrequest && avs_address == ADDR_MCU_CONTROL |->
        avs_readdata[31:8] == 24'h0 && avs_readdata[6:5] == 2'h0 && avs_readdata[3:2] == 2'h0)
        else $error("unused control bits read nonzero");
    a_reset_target: assert property (since_rst > 4'h3 |->
        reset_target == (boot_reset_fuse ? RESET_ADDR_APP : bs)) else $error("reset target wrong");
    a_base_legal: assert property (since_rst > 4'h3 |->
        vector_base == FIRST_IRQ_OFFSET || vector_base == bs + FIRST_IRQ_OFFSET) else $error("vector base wrong");
    a_base_guard: assert property ($changed(vector_base) && since_rst > 4'h3 |->
        $past(ctl_wr, 1) || $past(ctl_wr, 2) || $past(ctl_wr, 3)) else $error("vector base moved without write");
    a_pullup_follow: assert property (ctl_wr ##2 1'b1 |->
        global_pullup_disable == $past(avs_writedata[BIT_PULLUP_DISABLE], 2)) else $error("pull-up disable stale");
    a_block_start: assert property ($rose(irq_block) |-> $past(unl_wr))
        else $error("block rose without unlock write");
    a_block_end: assert property (s_unl_quiet |=> !irq_block)
        else $error("block outlived unlock window");
    a_gate_cause: assert property (irq_gated |-> $past(irq_request) && !irq_block)
        else $error("interrupt passed while blocked");
    a_lock_mask: assert property (since_rst > 4'h3 && lock_c && $past(lock_c) && $past(lock_c, 2) |->
        !irq_gated) else $error("interrupt passed under boot lock");
endmodule

bind ivp_top ivp_top_properties u_props (.*);

//--- ivp_top_test.sv
/*
 * Self-checking bench for ivp_top with a behavioural core model.
 * Assumes the bench is the Avalon-MM master and drives the straps.
 */
module ivp_top_test
    import ivp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              core_clk, rst_n, avs_read, avs_write, avs_waitrequest, sel;
    logic              boot_reset_fuse, app_side_boot_lock, boot_side_boot_lock, irq_request;
    logic              instr_retire, irq_gated, irq_block, global_pullup_disable, debug_port_disable;
    logic [ADDR_W-1:0] avs_address;
    logic [31:0]       avs_writedata, avs_readdata, rd, d;
    logic [3:0]        avs_byteenable;
    logic [1:0]        boot_size_fuses;
    logic [PC_W-1:0]   fetch_addr, pc_goal, reset_target, vector_base;
    int                errors, compares, c;
    ivp_top u_dut (.*);
    ivp_core_model u_core (.*);
    always #50 core_clk = ~core_clk;
    // ==========
    // Helpers
    function automatic logic [15:0] bs(input logic [1:0] z);
        bs = z == 2'h0 ? BOOT_START_SZ0 : z == 2'h1 ? BOOT_START_SZ1 : z == 2'h2 ? BOOT_START_SZ2 : BOOT_START_SZ3;
    endfunction
    function automatic logic [31:0] vq(input logic [5:0] n, input logic s, input logic [1:0] z);
        vq = {15'h0, 1'b1, {9'h0, n - 6'h1, 1'b0} + (s ? bs(z) : 16'h0)};
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= dat;
        avs_write <= wr;
        avs_read <= !wr;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        chk("bus answer", n < 20, 1'b1);
    endtask
    task automatic rchk(input string what, input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask
    task automatic move(input logic s);
        bus(1'b1, ADDR_MCU_CONTROL, 32'h01);
        bus(1'b1, ADDR_MCU_CONTROL, {30'h0, s, 1'b0});
        sel = s;
    endtask
    task automatic do_reset(input logic [1:0] z, input logic rf, input logic lk);
        @(posedge core_clk);
        rst_n <= 1'b0;
        boot_size_fuses <= z;
        boot_reset_fuse <= rf;
        app_side_boot_lock <= lk;
        boot_side_boot_lock <= lk;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        sel = 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
    // ==========
    // Watchdog
    initial
    begin
        #3000000;
        errors++;
        close_out();
    end
    // ==========
    // Tests
    initial
    begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        {avs_read, avs_write, irq_request} = 3'h0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        {boot_reset_fuse, app_side_boot_lock, boot_side_boot_lock} = 3'h7;
        boot_size_fuses = 2'h0;
        pc_goal = 16'h0100;
        d = $urandom(32'h78326b3e);
        for (c = 0; c < 4; c++)
        begin
            do_reset(c[1:0], c[0], 1'b1);
            chk("reset_target", reset_target, c[0] ? RESET_ADDR_APP : bs(c[1:0]));
            rchk("control reset", ADDR_MCU_CONTROL, 32'h0);
            chk("vector_base app", vector_base, FIRST_IRQ_OFFSET);
            bus(1'b1, ADDR_MCU_CONTROL, 32'h02);
            rchk("select locked", ADDR_MCU_CONTROL, 32'h0);
            move(1'b1);
            rchk("select moved", ADDR_MCU_CONTROL, 32'h02);
            repeat (3) @(posedge core_clk);
            chk("vector_base boot", vector_base, bs(c[1:0]) + FIRST_IRQ_OFFSET);
            for (int v = VEC_T3_CAPTURE; v <= VEC_PROG_STORE_RDY; v++)
            begin
                bus(1'b1, ADDR_VECTOR_QUERY, v);
                rchk("vector address", ADDR_VECTOR_ADDRESS, vq(v[5:0], 1'b1, c[1:0]));
            end
        end
        $display("test placement done");
        irq_request <= 1'b1;
        bus(1'b1, ADDR_MCU_CONTROL, 32'h01);
        @(posedge core_clk);
        chk("irq_block", irq_block, 1'b1);
        chk("irq_gated blocked", irq_gated, 1'b0);
        repeat (6) @(posedge core_clk);
        chk("irq_gated free", irq_gated, 1'b1);
        bus(1'b1, ADDR_MCU_CONTROL, 32'h00);
        rchk("unlock expired", ADDR_MCU_CONTROL, 32'h02);
        avs_byteenable <= 4'h0;
        bus(1'b1, ADDR_MCU_CONTROL, 32'h10);
        avs_byteenable <= 4'hF;
        rchk("lane off", ADDR_MCU_CONTROL, 32'h02);
        rchk("unmapped", 4'h2, 32'h0);
        repeat (20)
        begin
            d = $urandom & 32'hFFFF_FFFE;
            bus(1'b1, ADDR_MCU_CONTROL, d);
            rchk("control data", ADDR_MCU_CONTROL, (d & 32'h90) | {30'h0, sel, 1'b0});
            chk("pull-up disable", global_pullup_disable, d[BIT_PULLUP_DISABLE]);
            chk("debug disable", debug_port_disable, d[BIT_DEBUG_DISABLE]);
            d = VEC_FIRST + $urandom_range(37);
            bus(1'b1, ADDR_VECTOR_QUERY, d);
            rchk("random vector", ADDR_VECTOR_ADDRESS, vq(d[5:0], sel, 2'h3));
        end
        $display("test control done");
        do_reset(2'h1, 1'b1, 1'b0);
        pc_goal <= BOOT_START_SZ1;
        repeat (6) @(posedge core_clk);
        chk("boot code masked", irq_gated, 1'b0);
        rchk("status boot", ADDR_PLACEMENT, 32'h6);
        pc_goal <= 16'h0100;
        repeat (6) @(posedge core_clk);
        chk("app code free", irq_gated, 1'b1);
        move(1'b1);
        repeat (6) @(posedge core_clk);
        chk("app code masked", irq_gated, 1'b0);
        rchk("status app", ADDR_PLACEMENT, 32'h2);
        pc_goal <= BOOT_START_SZ1;
        repeat (6) @(posedge core_clk);
        chk("boot code free", irq_gated, 1'b1);
        $display("test lockout done");
        close_out();
    end
endmodule
